// ---- bench/vsti_cam_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module vsti_cam_model (
  output logic       ext_pixel_clock_in_se,
  output logic       ext_line_sync_in,
  output logic       ext_frame_sync_in,
  output logic       ext_composite_sync_in,
  output logic [3:0] ext_event_line_i
);
  logic lpol = 1'b0;
  initial begin
    ext_pixel_clock_in_se = 1'b0;
    ext_line_sync_in = 1'b0;
    ext_frame_sync_in = 1'b0;
    ext_composite_sync_in = 1'b0;
    ext_event_line_i = 4'h0;
  end
  // Pixel clock runs only inside frames, as a camera in external lock does
  task automatic pix(input int n);
    repeat (n) begin
      #40 ext_pixel_clock_in_se = 1'b1;
      #40 ext_pixel_clock_in_se = 1'b0;
    end
  endtask
  // Offset by 1 ns so no pin moves on an hclk edge
  task automatic setup(input logic p);
    #1 lpol = p;
    ext_line_sync_in = p;
  endtask
  task automatic frame(input int lines);
    #1 ext_frame_sync_in = 1'b1;
    pix(2);
    ext_frame_sync_in = 1'b0;
    repeat (lines) begin
      ext_line_sync_in = ~lpol;
      pix(2);
      ext_line_sync_in = lpol;
      pix(6);
    end
  endtask
  task automatic cs(input logic v);
    #1 ext_composite_sync_in = v;
  endtask
  task automatic ext_event_line(input int k, input logic v);
    #1 ext_event_line_i[k] = v;
  endtask
endmodule // vsti_cam_model
`default_nettype wire

// ---- bench/vsti_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module vsti_top_tb;
  import vsti_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, int_line_sync = 0, int_frame_sync = 0;
  logic int_composite_sync = 0, int_sample_en = 0, acq_active_flag = 0, acq_done = 0;
  logic ext_pixel_clock_in_diff = 0, hreadyout, hresp, composite_sync_out, gen_pixel_clock_out;
  logic gen_pixel_clock_out_diff_sel, sample_en, line_start, frame_start, acq_start, acq_stop;
  logic ext_pixel_clock_in_se, ext_line_sync_in, ext_frame_sync_in, ext_composite_sync_in;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  ext_event_line_i, ext_event_line_o, ext_event_line_oe_n, cam_ctrl_out;
  wire         hready;
  int n_errors = 0, check_count = 0, n_ls, n_fs, n_se, n_st, n_sp, n_cam, n_pe, n_go, n_tp;
  assign hready = hreadyout;
  vsti_top vsti_top_i (.*);
  vsti_cam_model cam (.*);
  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    n_ls += (line_start === 1'b1);
    n_fs += (frame_start === 1'b1);
    n_se += (sample_en === 1'b1);
    n_st += (acq_start === 1'b1);
    n_sp += (acq_stop === 1'b1);
    n_cam += (cam_ctrl_out[0] === 1'b1);
    n_tp += (ext_event_line_o[2] === 1'b1);
  end
  always @(posedge ext_pixel_clock_in_se) n_pe++;
  always @(posedge gen_pixel_clock_out) n_go++;
  task automatic clr();
    {n_ls, n_fs, n_se, n_st, n_sp, n_cam, n_pe, n_go, n_tp} = '0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Holds each phase until hready is sampled high; waits are bounded
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w; hsize <= 3'h2;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) begin n_errors++; end_sim(); end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic t_reset();
    chk("oe_n", 32'hF, 32'(ext_event_line_oe_n));
    xfer(0, OFF_EXT_EVENT_LINE_WIDTH, 0); chk("ext_event_line_width", 32'(EXT_EVENT_LINE_WIDTH_RST), r);
    chk("hresp", 0, 32'(hresp));
    xfer(0, 8'h20, 0); chk("unmapped", 0, r);
    xfer(1, OFF_CAM_WIDTH, 32'h5); xfer(0, OFF_CAM_WIDTH, 0); chk("cam_width", 5, r);
    $display("reset test done");
  endtask
  task automatic t_ext_event_line();
    xfer(1, OFF_EXT_EVENT_LINE_CFG, 32'h0000_0600); wt(6); clr();
    cam.ext_event_line(0, 1); wt(20); cam.ext_event_line(0, 0); wt(20);
    cam.ext_event_line(1, 1); wt(20); cam.ext_event_line(1, 0); wt(20);
    chk("acq_start", 1, n_st);
    chk("acq_stop", 1, n_sp);
    $display("trigger input test done");
  endtask
  task automatic t_out();
    xfer(1, OFF_EXT_EVENT_LINE_CFG, 32'h5181_0600); acq_active_flag <= 1'b1; wt(4);
    chk("oe_n", 32'h3, 32'(ext_event_line_oe_n));
    chk("out", 32'h3, 32'(ext_event_line_o[3:2]));
    acq_active_flag <= 1'b0; wt(4);
    chk("status", 0, 32'(ext_event_line_o[3]));
    xfer(1, OFF_EXT_EVENT_LINE_CFG, 32'h0009_0000); wt(2); clr();
    xfer(1, OFF_FIRE, 32'h4); wt(30);
    chk("ext_event_line_pulse", 32'(EXT_EVENT_LINE_WIDTH_RST), n_tp);
    $display("trigger output test done");
  endtask
  task automatic t_cam();
    xfer(1, OFF_CAM_CFG, 32'h21); wt(2);
    chk("cam_static", 1, 32'(cam_ctrl_out[1]));
    clr(); xfer(1, OFF_FIRE, 32'h10); wt(20);
    chk("cam_pulse", 5, n_cam);
    $display("camera test done");
  endtask
  task automatic t_lock();
    cam.setup(1); xfer(1, OFF_CTRL, 32'h22); wt(8); clr();
    cam.frame(3); wt(10);
    chk("lines", 3, n_ls);
    chk("frames", 1, n_fs);
    chk("samples", n_pe, n_se);
    // Differential receiver selected while only the single-ended pin toggles
    xfer(1, OFF_CTRL, 32'h32); wt(8); clr();
    cam.frame(1); wt(10);
    chk("pclk_diff_sel", 0, n_se);
    $display("external lock test done");
  endtask
  task automatic t_composite_sync();
    xfer(1, OFF_CTRL, 32'h1); wt(8); clr();
    cam.cs(1); wt(6);
    chk("composite_sync_copy", 1, 32'(composite_sync_out));
    chk("composite_sync_line", 1, n_ls);
    xfer(1, OFF_CTRL, 32'h0); wt(6);
    chk("composite_sync_std", 0, 32'(composite_sync_out));
    int_composite_sync <= 1'b1; wt(6);
    chk("composite_sync_std", 1, 32'(composite_sync_out));
    xfer(1, OFF_CTRL, 32'h100); wt(3);
    chk("gen_pixel_clock_out_diff", 1, 32'(gen_pixel_clock_out_diff_sel));
    $display("composite sync test done");
  endtask
  task automatic t_gen_pixel_clock_out();
    logic [31:0] v[2] = '{32'hFFFF_FFFF, 32'h0};
    logic [31:0] inc[2] = '{GEN_PIXEL_CLOCK_OUT_INC_MAX, GEN_PIXEL_CLOCK_OUT_INC_MIN};
    int e;
    for (int i = 0; i < 2; i++) begin
      xfer(1, OFF_GEN_PIXEL_CLOCK_OUT, v[i]); wt(4); clr(); wt(1000);
      e = int'((64'd1000 * inc[i]) >> 32);
      chk("gen_pixel_clock_out", 1, 32'(n_go >= e - 1 && n_go <= e + 1));
    end
    $display("pixel clock output test done");
  endtask
  initial begin
    wt(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_ext_event_line();
    t_out();
    t_cam();
    t_lock();
    t_composite_sync();
    t_gen_pixel_clock_out();
    end_sim();
  end
endmodule // vsti_top_tb
`default_nettype wire

// ---- verilog/vsti_pkg.sv ----
`default_nettype none
package vsti_pkg;
  localparam longint unsigned CLK_HZ          = 250_000_000;
  localparam longint unsigned GEN_PIXEL_CLOCK_OUT_MIN_HZ  = 11_000_000;
  localparam longint unsigned GEN_PIXEL_CLOCK_OUT_MAX_HZ  = 40_000_000;
  // Phase step of the 32-bit accumulator; the lower limit rounds up, the upper rounds down
  localparam logic [31:0] GEN_PIXEL_CLOCK_OUT_INC_MIN =
    32'(((GEN_PIXEL_CLOCK_OUT_MIN_HZ << 32) + CLK_HZ - 1) / CLK_HZ);
  localparam logic [31:0] GEN_PIXEL_CLOCK_OUT_INC_MAX = 32'((GEN_PIXEL_CLOCK_OUT_MAX_HZ << 32) / CLK_HZ);
  localparam logic [31:0] GEN_PIXEL_CLOCK_OUT_INC_RST = GEN_PIXEL_CLOCK_OUT_INC_MIN;

  localparam int N_EXT_EVENT_LINE = 4;
  localparam int N_CAM  = 4;
  localparam int PW_W   = 16;

  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_GEN_PIXEL_CLOCK_OUT    = 8'h04;
  localparam logic [7:0] OFF_EXT_EVENT_LINE_CFG   = 8'h08;
  localparam logic [7:0] OFF_EXT_EVENT_LINE_WIDTH = 8'h0C;
  localparam logic [7:0] OFF_FIRE       = 8'h10;
  localparam logic [7:0] OFF_CAM_CFG    = 8'h14;
  localparam logic [7:0] OFF_CAM_WIDTH  = 8'h18;
  localparam logic [7:0] OFF_STATUS     = 8'h1C;

  localparam int FIRE_EXT_EVENT_LINE_LSB = 0;
  localparam int FIRE_CAM_LSB  = 4;
  localparam int ST_EXT_EVENT_LINE_LSB   = 0;
  localparam int ST_ACQ_ACTIVE = 4;
  localparam int ST_ACQ_DONE   = 5;
  localparam int ST_LINE       = 6;
  localparam int ST_FRAME      = 7;
  localparam int ST_MODE_LSB   = 8;

  // Positions in the synchroniser vector
  localparam int SY_PCLK_SE   = 0;
  localparam int SY_PCLK_DIFF = 1;
  localparam int SY_LINE      = 2;
  localparam int SY_FRAME     = 3;
  localparam int SY_COMPOSITE_SYNC     = 4;
  localparam int SY_EXT_EVENT_LINE_LSB  = 5;
  localparam int SY_W         = 9;

  localparam logic [8:0]      CTRL_RST       = 9'h000;
  localparam logic [31:0]     EXT_EVENT_LINE_CFG_RST   = 32'h0000_0000;
  localparam logic [15:0]     CAM_CFG_RST    = 16'h0000;
  localparam logic [PW_W-1:0] EXT_EVENT_LINE_WIDTH_RST = 16'h0010;
  localparam logic [PW_W-1:0] CAM_WIDTH_RST  = 16'h0010;

  typedef enum logic [2:0] {
    MODE_STANDARD, MODE_COMPOSITE_SYNC_EXT, MODE_EXT_LOCK, MODE_EXT_HV, MODE_EXT_HV_HLOCK
  } vsti_mode_t;
  typedef enum logic [1:0] {TO_STATIC, TO_PULSE, TO_STATUS} vsti_tout_t;
  typedef enum logic [1:0] {SS_LINE, SS_FRAME, SS_ACQ_ACTIVE, SS_ACQ_DONE} vsti_ssel_t;

  // Polarity bits: 1 inverts the pin before use; composite_sync_out still copies the raw composite pin
  typedef struct packed {
    logic       gen_pixel_clock_out_diff;
    logic       composite_sync_pol;
    logic       fsync_pol;
    logic       lsync_pol;
    logic       pclk_diff;
    logic       pclk_pol;
    vsti_mode_t mode;
  } vsti_ctrl_t;

  typedef struct packed {
    logic       level;
    vsti_ssel_t status_sel;
    vsti_tout_t out_mode;
    logic       stop;
    logic       falling;
    logic       out_en;
  } vsti_ext_event_line_cfg_t;

  typedef struct packed {
    logic invert;
    logic on_frame;
    logic level;
    logic dynamic;
  } vsti_cam_cfg_t;
endpackage
`default_nettype wire

// ---- verilog/vsti_pulse.sv ----
`timescale 1ns/1ns
`default_nettype none
module vsti_pulse
  import vsti_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            fire,
  input  wire logic [PW_W-1:0] width,
  output logic                 active
);
  logic [PW_W-1:0] cnt_q;

  // A fire while busy restarts the pulse; width zero gives no pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      active <= 1'b0;
    end else if (fire && width != '0) begin
      cnt_q  <= width;
      active <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q  <= cnt_q - 1'b1;
      active <= (cnt_q != 16'h0001);
    end
  end

  property p_pulse_start;
    @(posedge hclk) disable iff (!hresetn)
      (fire && width != '0) |=> active && cnt_q == $past(width);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

  property p_pulse_end;
    @(posedge hclk) disable iff (!hresetn)
      (active && cnt_q == 16'h0001 && !fire) |=> !active;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");
endmodule // vsti_pulse
`default_nettype wire

// ---- verilog/vsti_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module vsti_sync
  import vsti_pkg::*;
#(
  parameter int W = SY_W
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Only the second stage is visible to any logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // vsti_sync
`default_nettype wire

// ---- verilog/vsti_top.sv ----
// Function
// - External lock mode samples on edges of the external pixel clock input.
// - Software picks pixel clock input polarity and single-ended or differential receiver.
// - Line sync input polarity is programmable; leading edge starts a line.
// - External lock takes frames from frame sync input, polarity programmable.
// - Composite sync external mode times lines from the polarity-adjusted composite input.
// - Composite sync external mode copies the composite input to the composite output.
// - Standard mode drives composite output from internal synchronisation logic.
// - Outgoing pixel clock frequency is programmable between 11 and 40 MHz.
// - Trigger inputs start or stop acquisition on a per-line selected edge.
// - Trigger outputs give static level, timed pulse, or internal status.
// - Acquisition status can be reported on an output trigger line.
// - Camera control lines carry a static level or a timed pulse.
// - External lock takes line, frame and pixel timing all from the camera.
// - Line sync, frame sync, acquisition active and done route to triggers.
// - The pixel clock is never a trigger output source.
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module vsti_top
  import vsti_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              ext_pixel_clock_in_se,
  input  wire logic              ext_pixel_clock_in_diff,
  input  wire logic              ext_line_sync_in,
  input  wire logic              ext_frame_sync_in,
  input  wire logic              ext_composite_sync_in,
  input  wire logic              int_line_sync,
  input  wire logic              int_frame_sync,
  input  wire logic              int_composite_sync,
  input  wire logic              int_sample_en,
  input  wire logic              acq_active_flag,
  input  wire logic              acq_done,
  input  wire logic [N_EXT_EVENT_LINE-1:0] ext_event_line_i,
  output logic      [N_EXT_EVENT_LINE-1:0] ext_event_line_o,
  output logic      [N_EXT_EVENT_LINE-1:0] ext_event_line_oe_n,
  output logic      [N_CAM-1:0]  cam_ctrl_out,
  output logic                   composite_sync_out,
  output logic                   gen_pixel_clock_out,
  output logic                   gen_pixel_clock_out_diff_sel,
  output logic                   sample_en,
  output logic                   line_start,
  output logic                   frame_start,
  output logic                   acq_start,
  output logic                   acq_stop
);
  function automatic logic lead_edge(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic [31:0] clamp_inc(input logic [31:0] v);
    if (v < GEN_PIXEL_CLOCK_OUT_INC_MIN) return GEN_PIXEL_CLOCK_OUT_INC_MIN;
    if (v > GEN_PIXEL_CLOCK_OUT_INC_MAX) return GEN_PIXEL_CLOCK_OUT_INC_MAX;
    return v;
  endfunction

  vsti_ctrl_t                  ctrl_q;
  vsti_ext_event_line_cfg_t [N_EXT_EVENT_LINE-1:0] ext_event_line_cfg_q;
  vsti_cam_cfg_t  [N_CAM-1:0]  cam_cfg_q;
  logic [31:0]                 pclk_inc_q;
  logic [31:0]                 pclk_acc_q;
  logic [PW_W-1:0]             ext_event_line_width_q;
  logic [PW_W-1:0]             cam_width_q;
  logic [N_EXT_EVENT_LINE-1:0]           fire_ext_event_line_q;
  logic [N_CAM-1:0]            fire_cam_q;
  logic                        wr_pend_q;
  logic                        rd_pend_q;
  logic [7:0]                  addr_q;
  logic [SY_W-1:0]             sy;
  logic                        pclk_prev_q;
  logic                        line_prev_q;
  logic                        frame_prev_q;
  logic [N_EXT_EVENT_LINE-1:0]           ext_event_line_prev_q;

  // Bus decode
  wire         bus_take = hsel & htrans[1] & hready;
  wire         wr_ctrl  = wr_pend_q & (addr_q == OFF_CTRL);
  wire         wr_fire  = wr_pend_q & (addr_q == OFF_FIRE);
  logic [31:0] rd_mux;

  // Mode decode
  wire ext_lock    = ctrl_q.mode == MODE_EXT_LOCK;
  wire composite_sync_ext   = ctrl_q.mode == MODE_COMPOSITE_SYNC_EXT;
  wire ext_line    = ext_lock | (ctrl_q.mode == MODE_EXT_HV) | (ctrl_q.mode == MODE_EXT_HV_HLOCK);
  wire pclk_raw    = ctrl_q.pclk_diff ? sy[SY_PCLK_DIFF] : sy[SY_PCLK_SE];
  wire pclk_lvl    = pclk_raw ^ ctrl_q.pclk_pol;
  wire composite_sync_lvl   = sy[SY_COMPOSITE_SYNC] ^ ctrl_q.composite_sync_pol;
  wire ext_ln_lvl  = sy[SY_LINE] ^ ctrl_q.lsync_pol;
  wire ext_fr_lvl  = sy[SY_FRAME] ^ ctrl_q.fsync_pol;
  wire line_lvl    = ext_line ? ext_ln_lvl : (composite_sync_ext ? composite_sync_lvl : int_line_sync);
  wire frame_lvl   = ext_line ? ext_fr_lvl : int_frame_sync;
  wire composite_sync_sel   = composite_sync_ext ? sy[SY_COMPOSITE_SYNC] : int_composite_sync;

  wire [N_EXT_EVENT_LINE-1:0] ext_event_line_pin = sy[SY_EXT_EVENT_LINE_LSB +: N_EXT_EVENT_LINE];
  logic [N_EXT_EVENT_LINE-1:0] ext_event_line_lvl;
  logic [N_EXT_EVENT_LINE-1:0] ext_event_line_edge;
  logic [N_EXT_EVENT_LINE-1:0] ext_event_line_is_stop;
  logic [N_EXT_EVENT_LINE-1:0] ext_event_line_val;
  logic [N_EXT_EVENT_LINE-1:0] ext_event_line_pulse;
  logic [N_CAM-1:0]  cam_fire;
  logic [N_CAM-1:0]  cam_pulse;
  logic [N_CAM-1:0]  cam_val;

  vsti_sync #(.W(SY_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({ext_event_line_i, ext_composite_sync_in, ext_frame_sync_in,
                ext_line_sync_in, ext_pixel_clock_in_diff, ext_pixel_clock_in_se}),
    .q       (sy)
  );

  for (genvar i = 0; i < N_EXT_EVENT_LINE; i++) begin : g_ext_event_line
    logic status_val;
    assign ext_event_line_lvl[i]     = ext_event_line_pin[i] ^ ext_event_line_cfg_q[i].falling;
    assign ext_event_line_edge[i]    = ~ext_event_line_cfg_q[i].out_en & lead_edge(ext_event_line_lvl[i], ext_event_line_prev_q[i]);
    assign ext_event_line_is_stop[i] = ext_event_line_cfg_q[i].stop;
    // Status choices hold no pixel clock: it is far too fast for these lines
    assign status_val = (ext_event_line_cfg_q[i].status_sel == SS_LINE)  ? line_lvl :
                        (ext_event_line_cfg_q[i].status_sel == SS_FRAME) ? frame_lvl :
                        (ext_event_line_cfg_q[i].status_sel == SS_ACQ_ACTIVE) ? acq_active_flag :
                        acq_done;
    assign ext_event_line_val[i] = (ext_event_line_cfg_q[i].out_mode == TO_PULSE)  ? ext_event_line_pulse[i] :
                         (ext_event_line_cfg_q[i].out_mode == TO_STATUS) ? status_val :
                         ext_event_line_cfg_q[i].level;
    vsti_pulse u_ext_event_line_pulse (
      .hclk    (hclk),
      .hresetn (hresetn),
      .fire    (fire_ext_event_line_q[i]),
      .width   (ext_event_line_width_q),
      .active  (ext_event_line_pulse[i])
    );
  end

  for (genvar i = 0; i < N_CAM; i++) begin : g_cam
    assign cam_fire[i] = cam_cfg_q[i].on_frame ? frame_start : fire_cam_q[i];
    assign cam_val[i]  = cam_cfg_q[i].dynamic ? (cam_pulse[i] ^ cam_cfg_q[i].invert)
                                               : cam_cfg_q[i].level;
    vsti_pulse u_cam_pulse (
      .hclk    (hclk),
      .hresetn (hresetn),
      .fire    (cam_fire[i]),
      .width   (cam_width_q),
      .active  (cam_pulse[i])
    );
  end

  always_comb begin
    unique case (addr_q)
      OFF_CTRL:       rd_mux = {23'h000000, ctrl_q};
      OFF_GEN_PIXEL_CLOCK_OUT:    rd_mux = pclk_inc_q;
      OFF_EXT_EVENT_LINE_CFG:   rd_mux = ext_event_line_cfg_q;
      OFF_EXT_EVENT_LINE_WIDTH: rd_mux = {16'h0000, ext_event_line_width_q};
      OFF_CAM_CFG:    rd_mux = {16'h0000, cam_cfg_q};
      OFF_CAM_WIDTH:  rd_mux = {16'h0000, cam_width_q};
      OFF_STATUS:     rd_mux = {21'h000000, ctrl_q.mode, frame_lvl, line_lvl,
                                acq_done, acq_active_flag, ext_event_line_pin};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // Reads take one wait state so a write in the cycle before is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= bus_take & hwrite;
      rd_pend_q <= bus_take & ~hwrite;
      hreadyout <= ~(bus_take & ~hwrite);
      if (bus_take) addr_q <= {haddr[7:2], 2'b00};
      if (rd_pend_q) hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q       <= vsti_ctrl_t'(CTRL_RST);
      pclk_inc_q   <= GEN_PIXEL_CLOCK_OUT_INC_RST;
      ext_event_line_cfg_q   <= EXT_EVENT_LINE_CFG_RST;
      ext_event_line_width_q <= EXT_EVENT_LINE_WIDTH_RST;
      cam_cfg_q    <= CAM_CFG_RST;
      cam_width_q  <= CAM_WIDTH_RST;
    end else if (wr_pend_q) begin
      if (wr_ctrl) ctrl_q <= vsti_ctrl_t'(hwdata[8:0]);
      if (addr_q == OFF_GEN_PIXEL_CLOCK_OUT) pclk_inc_q <= clamp_inc(hwdata);
      if (addr_q == OFF_EXT_EVENT_LINE_CFG) ext_event_line_cfg_q <= hwdata;
      if (addr_q == OFF_EXT_EVENT_LINE_WIDTH) ext_event_line_width_q <= hwdata[PW_W-1:0];
      if (addr_q == OFF_CAM_CFG) cam_cfg_q <= hwdata[15:0];
      if (addr_q == OFF_CAM_WIDTH) cam_width_q <= hwdata[PW_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fire_ext_event_line_q <= '0;
      fire_cam_q  <= '0;
    end else begin
      fire_ext_event_line_q <= wr_fire ? hwdata[FIRE_EXT_EVENT_LINE_LSB +: N_EXT_EVENT_LINE] : '0;
      fire_cam_q  <= wr_fire ? hwdata[FIRE_CAM_LSB +: N_CAM] : '0;
    end
  end

  // Accumulator MSB gives a jitter of one hclk period, traded for any rate in range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_acc_q          <= 32'h0000_0000;
      gen_pixel_clock_out <= 1'b0;
      gen_pixel_clock_out_diff_sel    <= 1'b0;
    end else begin
      pclk_acc_q          <= pclk_acc_q + pclk_inc_q;
      gen_pixel_clock_out <= pclk_acc_q[31];
      gen_pixel_clock_out_diff_sel    <= ctrl_q.gen_pixel_clock_out_diff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_prev_q  <= 1'b0;
      line_prev_q  <= 1'b0;
      frame_prev_q <= 1'b0;
      ext_event_line_prev_q  <= '0;
    end else begin
      pclk_prev_q  <= pclk_lvl;
      line_prev_q  <= line_lvl;
      frame_prev_q <= frame_lvl;
      ext_event_line_prev_q  <= ext_event_line_lvl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_en          <= 1'b0;
      line_start         <= 1'b0;
      frame_start        <= 1'b0;
      composite_sync_out <= 1'b0;
      acq_start          <= 1'b0;
      acq_stop           <= 1'b0;
    end else begin
      sample_en   <= ext_lock ? lead_edge(pclk_lvl, pclk_prev_q) : int_sample_en;
      line_start  <= lead_edge(line_lvl, line_prev_q);
      frame_start <= lead_edge(frame_lvl, frame_prev_q);
      composite_sync_out <= composite_sync_sel;
      acq_start   <= |(ext_event_line_edge & ~ext_event_line_is_stop);
      acq_stop    <= |(ext_event_line_edge & ext_event_line_is_stop);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_event_line_o    <= '0;
      ext_event_line_oe_n <= '1;
      cam_ctrl_out        <= '0;
    end else begin
      ext_event_line_o    <= ext_event_line_val;
      ext_event_line_oe_n <= ~{ext_event_line_cfg_q[3].out_en, ext_event_line_cfg_q[2].out_en,
                               ext_event_line_cfg_q[1].out_en, ext_event_line_cfg_q[0].out_en};
      cam_ctrl_out        <= cam_val;
    end
  end

  sequence s_pclk_rise;
    ext_lock && !pclk_lvl ##1 ext_lock && pclk_lvl;
  endsequence
  property p_pclk_sample;
    @(posedge hclk) disable iff (!hresetn) s_pclk_rise |=> sample_en;
  endproperty
  a_pclk_sample: assert property (p_pclk_sample) else $error("no sample on pclk edge");

  property p_pclk_quiet;
    @(posedge hclk) disable iff (!hresetn) (ext_lock && pclk_lvl == pclk_prev_q) |=> !sample_en;
  endproperty
  a_pclk_quiet: assert property (p_pclk_quiet) else $error("sample without pclk edge");

  sequence s_line_rise;
    ext_line && !ext_ln_lvl ##1 ext_line && ext_ln_lvl;
  endsequence
  property p_line_start;
    @(posedge hclk) disable iff (!hresetn) s_line_rise |=> line_start;
  endproperty
  a_line_start: assert property (p_line_start) else $error("line start missed");

  property p_frame_start;
    @(posedge hclk) disable iff (!hresetn)
      (ext_lock && $rose(ext_fr_lvl)) |=> frame_start;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start missed");

  property p_composite_sync_line;
    @(posedge hclk) disable iff (!hresetn) (composite_sync_ext && $rose(composite_sync_lvl)) |=> line_start;
  endproperty
  a_composite_sync_line: assert property (p_composite_sync_line) else $error("composite_sync line missed");

  property p_composite_sync_copy;
    @(posedge hclk) disable iff (!hresetn) composite_sync_ext |=> composite_sync_out == $past(sy[SY_COMPOSITE_SYNC]);
  endproperty
  a_composite_sync_copy: assert property (p_composite_sync_copy) else $error("composite_sync not copied");

  property p_composite_sync_std;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl_q.mode == MODE_STANDARD) |=> composite_sync_out == $past(int_composite_sync);
  endproperty
  a_composite_sync_std: assert property (p_composite_sync_std) else $error("composite_sync not internal");

  property p_inc_range;
    @(posedge hclk) disable iff (!hresetn)
      pclk_inc_q >= GEN_PIXEL_CLOCK_OUT_INC_MIN && pclk_inc_q <= GEN_PIXEL_CLOCK_OUT_INC_MAX;
  endproperty
  a_inc_range: assert property (p_inc_range) else $error("pclk out out of range");

  property p_ext_event_line_start;
    @(posedge hclk) disable iff (!hresetn)
      (!ext_event_line_cfg_q[0].out_en && !ext_event_line_cfg_q[0].stop && !ext_event_line_prev_q[0] && ext_event_line_lvl[0])
        |=> acq_start ##1 (!acq_start || $past(|ext_event_line_edge));
  endproperty
  a_ext_event_line_start: assert property (p_ext_event_line_start) else $error("trigger start wrong");

  property p_ext_event_line_static;
    @(posedge hclk) disable iff (!hresetn)
      (ext_event_line_cfg_q[0].out_en && ext_event_line_cfg_q[0].out_mode == TO_STATIC)
        |=> !ext_event_line_oe_n[0] && ext_event_line_o[0] == $past(ext_event_line_cfg_q[0].level);
  endproperty
  a_ext_event_line_static: assert property (p_ext_event_line_static) else $error("static trigger wrong");

  property p_ext_event_line_status;
    @(posedge hclk) disable iff (!hresetn)
      (ext_event_line_cfg_q[3].out_mode == TO_STATUS && ext_event_line_cfg_q[3].status_sel == SS_ACQ_ACTIVE)
        |=> ext_event_line_o[3] == $past(acq_active_flag);
  endproperty
  a_ext_event_line_status: assert property (p_ext_event_line_status) else $error("status not routed");
endmodule // vsti_top
`default_nettype wire
